// ### core/pfp_prog_port.sv
`timescale 1ns/100ps
`default_nettype none
`include "pfp_cfg.svh"
// Functional notes
// - a started write, lock or erase runs to completion on the device's own timer.
// - mode 00011 with strobe and voltage pin high makes the device drive the addressed byte.
// - mode 11111 with 12V and a strobe pulse programs lock bit 1, ignoring data and address.
// - mode 11100 with 12V and a strobe pulse programs lock bit 2, ignoring data and address.
// - mode 10110 with 12V and a strobe pulse programs lock bit 3, ignoring data and address.
// - mode 11010 with strobe and voltage pin high shows lock bits 1..3 on port 0 bits 2..4.
// - mode 10100 with 12V and a strobe pulse erases the whole array.
// - mode 00000 with strobe and voltage pin high shows an identity byte chosen by the address.
// - the ready/busy pin shows whether a self-timed operation is still running.
module pfp_prog_port #(
  parameter int ADDR_W = 13,
  parameter int PROG_CYCLES = `PFP_PROG_TIME_NS / `PFP_CLK_PERIOD_NS,
  parameter logic [7:0] MAKER_CODE = 8'h5a, // arbitrary value
  parameter logic [7:0] DEV1_CODE = 8'ha5, // arbitrary value
  parameter logic [7:0] DEV2_CODE = 8'h3c // arbitrary value
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic resetn_i,
  // control pins
  input wire logic reset_pin_i,
  input wire logic external_store_strobe_n_i,
  input wire logic program_strobe_i,
  input wire logic program_voltage_pin_i,
  input wire logic program_voltage_pin_hv_i,
  input wire logic [4:0] mode_select_i,
  // address pins
  input wire logic [12:0] addr_i,
  // port 0 data
  input wire logic [7:0] port0_i,
  output logic [7:0] port0_o,
  output logic port0_oe_o,
  // status
  output logic ready_busy_pin_o
);
  typedef struct packed {
    pfp_pkg::pfp_pins_t s1;
    pfp_pkg::pfp_pins_t s2;
    pfp_pkg::pfp_pins_t s3;
    pfp_pkg::pfp_pins_t f;
    pfp_pkg::pfp_state_t state;
    logic [15:0] cnt;
    logic [4:0] op;
    logic [12:0] addr;
    logic [7:0] data;
    logic [2:0] lock;
    logic [7:0] rdout;
    logic oe;
    logic ready;
  } pfp_regs_t;

  pfp_regs_t q;
  pfp_regs_t n;
  logic [7:0] mem [0:(1 << ADDR_W) - 1];
  logic [7:0] mem_rd;
  logic mem_we;
  logic [12:0] mem_wa;
  logic [7:0] mem_wd;
  logic start;
  logic prog_en;
  logic rd_ok;

  assign mem_rd = mem[q.f.addr];

  always_comb
  begin
    n = q;
    mem_we = 1'b0;
    mem_wa = q.addr;
    mem_wd = q.data;
    n.s1 = '{rst: reset_pin_i, store_n: external_store_strobe_n_i, prog: program_strobe_i,
             vpp: program_voltage_pin_i, vpp_hv: program_voltage_pin_hv_i,
             mode: mode_select_i, addr: addr_i, data: port0_i};
    n.s2 = q.s1;
    n.s3 = q.s2;
    // a change is taken only once two stages agree, filtering a pin caught mid-edge
    if (q.s2 == q.s3)
    begin
      n.f = q.s3;
    end
    prog_en = q.f.rst && !q.f.store_n;
    rd_ok = prog_en && q.f.prog && q.f.vpp && !q.f.vpp_hv;
    // operation begins on the falling edge of the strobe pulse
    start = prog_en && q.f.vpp_hv && q.f.prog && !n.f.prog && q.state == pfp_pkg::PFP_IDLE;
    n.oe = 1'b0;
    n.rdout = 8'h00;
    if (rd_ok && q.state == pfp_pkg::PFP_IDLE)
    begin
      case (q.f.mode)
        `PFP_MODE_READ:
        begin
          n.oe = 1'b1;
          n.rdout = mem_rd;
        end
        `PFP_MODE_LOCKRD:
        begin
          n.oe = 1'b1;
          n.rdout[`PFP_LOCKRD_LSB +: 3] = q.lock;
        end
        `PFP_MODE_ID:
        begin
          n.oe = 1'b1;
          // selected by address bits 11..8 with the low byte zero; bit 12 is don't care
          if (q.f.addr[11:0] == `PFP_ID_SEL_DEV1)
          begin
            n.rdout = DEV1_CODE;
          end
          else if (q.f.addr[11:0] == `PFP_ID_SEL_DEV2)
          begin
            n.rdout = DEV2_CODE;
          end
          else
          begin
            n.rdout = MAKER_CODE;
          end
        end
        default:
        begin
          n.oe = 1'b0;
        end
      endcase
    end
    case (q.state)
      pfp_pkg::PFP_IDLE:
      begin
        n.cnt = 16'h0000;
        if (start)
        begin
          n.op = q.f.mode;
          n.addr = q.f.addr;
          n.data = q.f.data;
          if (q.f.mode == `PFP_MODE_ERASE)
          begin
            n.state = pfp_pkg::PFP_ERASE;
          end
          else if (q.f.mode == `PFP_MODE_WRITE || q.f.mode == `PFP_MODE_LOCK1 ||
                   q.f.mode == `PFP_MODE_LOCK2 || q.f.mode == `PFP_MODE_LOCK3)
          begin
            n.state = pfp_pkg::PFP_BUSY;
          end
        end
      end
      pfp_pkg::PFP_BUSY:
      begin
        n.cnt = q.cnt + 16'h0001;
        if (q.cnt == 16'(PROG_CYCLES - 1))
        begin
          n.state = pfp_pkg::PFP_IDLE;
          case (q.op)
            `PFP_MODE_WRITE: mem_we = 1'b1;
            `PFP_MODE_LOCK1: n.lock[0] = 1'b1;
            `PFP_MODE_LOCK2: n.lock[1] = 1'b1;
            `PFP_MODE_LOCK3: n.lock[2] = 1'b1;
            default: n.lock = q.lock;
          endcase
        end
      end
      pfp_pkg::PFP_ERASE:
      begin
        // one byte per cycle keeps the array a plain single-port memory
        n.cnt = q.cnt + 16'h0001;
        mem_we = 1'b1;
        mem_wa = q.cnt[12:0];
        mem_wd = `PFP_ERASED_BYTE;
        if (q.cnt == 16'((1 << ADDR_W) - 1))
        begin
          n.state = pfp_pkg::PFP_IDLE;
          n.lock = 3'b000;
        end
      end
      default:
      begin
        n.state = pfp_pkg::PFP_IDLE;
      end
    endcase
    n.ready = (n.state == pfp_pkg::PFP_IDLE);
  end

  always_ff @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      q <= '0;
      q.state <= pfp_pkg::PFP_IDLE;
      q.ready <= 1'b1;
    end
    else
    begin
      q <= n;
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (mem_we)
    begin
      mem[mem_wa] <= mem_wd;
    end
  end

  assign port0_o = q.rdout;
  assign port0_oe_o = q.oe;
  assign ready_busy_pin_o = q.ready;

  property p_self_time;
    @(posedge core_clk_i) disable iff (!resetn_i)
    (start && n.state == pfp_pkg::PFP_BUSY) |=> !ready_busy_pin_o ##[1:1000] ready_busy_pin_o;
  endproperty
  a_self_time: assert property (p_self_time) else $error("write did not self-complete");
  property p_read_code;
    @(posedge core_clk_i) disable iff (!resetn_i)
    (rd_ok && q.f.mode == `PFP_MODE_READ && q.ready) |=> port0_oe_o && port0_o == $past(mem_rd);
  endproperty
  a_read_code: assert property (p_read_code) else $error("code byte not driven");
  property p_lock1;
    @(posedge core_clk_i) disable iff (!resetn_i)
    (start && q.f.mode == `PFP_MODE_LOCK1) |-> ##[1:1000] q.lock[0];
  endproperty
  a_lock1: assert property (p_lock1) else $error("lock bit 1 not set");
  property p_lock2;
    @(posedge core_clk_i) disable iff (!resetn_i)
    (start && q.f.mode == `PFP_MODE_LOCK2 && !q.lock[1])
      |=> !q.lock[1] throughout (!ready_busy_pin_o [*8]);
  endproperty
  a_lock2: assert property (p_lock2) else $error("lock bit 2 set early");
  property p_lock3;
    @(posedge core_clk_i) disable iff (!resetn_i)
    $rose(q.lock[2]) |-> $past(q.op) == `PFP_MODE_LOCK3 && $rose(ready_busy_pin_o);
  endproperty
  a_lock3: assert property (p_lock3) else $error("lock bit 3 set wrongly");
  property p_lock_read;
    @(posedge core_clk_i) disable iff (!resetn_i)
    (rd_ok && q.f.mode == `PFP_MODE_LOCKRD && q.ready) |=> port0_o[4:2] == $past(q.lock);
  endproperty
  a_lock_read: assert property (p_lock_read) else $error("lock bits not shown");
  property p_erase;
    @(posedge core_clk_i) disable iff (!resetn_i)
    (q.state == pfp_pkg::PFP_ERASE && q.cnt == 16'h1fff) |=> q.lock == 3'b000 && ready_busy_pin_o;
  endproperty
  a_erase: assert property (p_erase) else $error("erase end wrong");
  property p_id;
    @(posedge core_clk_i) disable iff (!resetn_i)
    (rd_ok && q.f.mode == `PFP_MODE_ID && q.ready && q.f.addr[11:0] == `PFP_ID_SEL_DEV1)
      |=> port0_o == DEV1_CODE;
  endproperty
  a_id: assert property (p_id) else $error("identity byte wrong");
  property p_ready;
    @(posedge core_clk_i) disable iff (!resetn_i)
    (ready_busy_pin_o && !start) |=> ready_busy_pin_o;
  endproperty
  a_ready: assert property (p_ready) else $error("busy without start");
  c_write: cover property (@(posedge core_clk_i) start && q.f.mode == `PFP_MODE_WRITE);
  c_erase: cover property (@(posedge core_clk_i) q.state == pfp_pkg::PFP_ERASE);
  c_read: cover property (@(posedge core_clk_i) port0_oe_o && q.f.mode == `PFP_MODE_READ);
endmodule
`default_nettype wire

// ### core/pfp_cfg.svh
`ifndef PFP_CFG_SVH
`define PFP_CFG_SVH
`define PFP_CLK_PERIOD_NS 10
`define PFP_PROG_TIME_NS 2000
`define PFP_ERASED_BYTE 8'hff
`define PFP_MODE_WRITE 5'h0f
`define PFP_MODE_READ 5'h03
`define PFP_MODE_LOCK1 5'h1f
`define PFP_MODE_LOCK2 5'h1c
`define PFP_MODE_LOCK3 5'h16
`define PFP_MODE_LOCKRD 5'h1a
`define PFP_MODE_ERASE 5'h14
`define PFP_MODE_ID 5'h00
`define PFP_ID_SEL_DEV1 12'h100
`define PFP_ID_SEL_DEV2 12'h200
`define PFP_LOCKRD_LSB 2
`endif

// ### core/pfp_pkg.sv
`default_nettype none
package pfp_pkg;
  typedef struct packed {
    logic rst;
    logic store_n;
    logic prog;
    logic vpp;
    logic vpp_hv;
    logic [4:0] mode;
    logic [12:0] addr;
    logic [7:0] data;
  } pfp_pins_t;

  typedef enum logic [2:0] {
    PFP_IDLE = 3'b001,
    PFP_BUSY = 3'b010,
    PFP_ERASE = 3'b100
  } pfp_state_t;
endpackage
`default_nettype wire

// ### testbench/pfp_prog_model.sv
`timescale 1ns/100ps
`default_nettype none
module pfp_prog_model (
  // clock and device status
  input wire logic core_clk_i,
  input wire logic ready_busy_pin_i,
  // programming pins
  output logic reset_pin_o,
  output logic store_n_o,
  output logic strobe_o,
  output logic vpp_o,
  output logic hv_o,
  output logic [4:0] mode_o,
  output logic [12:0] addr_o,
  output logic [7:0] data_o
);
  initial
  begin
    reset_pin_o = 1'b1;
    store_n_o = 1'b0;
    strobe_o = 1'b1;
    vpp_o = 1'b1;
    hv_o = 1'b0;
    mode_o = 5'h00;
    addr_o = 13'h0000;
    data_o = 8'hff;
  end

  // address and data are held even where ignored, so a wrong latch still shows
  task automatic prog(input logic [4:0] m, input logic [12:0] a, input logic [7:0] d,
                      output logic busy, output logic ok);
    int n;
    @(posedge core_clk_i);
    #1;
    hv_o = 1'b1;
    mode_o = m;
    addr_o = a;
    data_o = d;
    repeat (8) @(posedge core_clk_i);
    #1 strobe_o = 1'b0;
    repeat (10) @(posedge core_clk_i);
    #1 busy = ~ready_busy_pin_i;
    repeat (14) @(posedge core_clk_i);
    #1 strobe_o = 1'b1; // about 240 ns low
    n = 0;
    // nothing changes until ready
    while (ready_busy_pin_i !== 1'b1 && n < 20000)
    begin
      @(posedge core_clk_i);
      #1;
      n++;
    end
    ok = (n < 20000);
    repeat (2) @(posedge core_clk_i);
    #1 hv_o = 1'b0;
    data_o = 8'hff;
  endtask

  task automatic rd(input logic [4:0] m, input logic [12:0] a);
    @(posedge core_clk_i);
    #1;
    hv_o = 1'b0;
    strobe_o = 1'b1;
    mode_o = m;
    addr_o = a;
    // released: external pull-ups
    data_o = 8'hff;
    repeat (8) @(posedge core_clk_i);
    #1;
  endtask
endmodule
`default_nettype wire

// ### testbench/tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "pfp_cfg.svh"
module tb;
  localparam logic [7:0] MK = 8'h5a; // arbitrary value
  localparam logic [7:0] D1 = 8'ha5; // arbitrary value
  localparam logic [7:0] D2 = 8'h3c; // arbitrary value
  logic core_clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic rst_p, st_n, strb, vpp, hv, oe, rdy;
  logic [4:0] mode;
  logic [12:0] addr;
  logic [7:0] pdat, p0_o;
  logic [7:0] exp_mem [0:8191];
  int err_total = 0;
  int comparisons = 0;
  int cycles = 0;

  always #5 core_clk_i = ~core_clk_i;

  pfp_prog_port #(.PROG_CYCLES(40), .MAKER_CODE(MK), .DEV1_CODE(D1), .DEV2_CODE(D2)) u_dut (
    .core_clk_i(core_clk_i), .resetn_i(resetn_i), .reset_pin_i(rst_p),
    .external_store_strobe_n_i(st_n), .program_strobe_i(strb), .program_voltage_pin_i(vpp),
    .program_voltage_pin_hv_i(hv), .mode_select_i(mode), .addr_i(addr),
    .port0_i(oe ? p0_o : pdat), .port0_o(p0_o), .port0_oe_o(oe), .ready_busy_pin_o(rdy));

  pfp_prog_model u_prog (
    .core_clk_i(core_clk_i), .ready_busy_pin_i(rdy), .reset_pin_o(rst_p), .store_n_o(st_n),
    .strobe_o(strb), .vpp_o(vpp), .hv_o(hv), .mode_o(mode), .addr_o(addr), .data_o(pdat));

  function automatic logic [7:0] lock_byte(input logic [2:0] l);
    return {3'h0, l, 2'h0};
  endfunction

  function automatic logic [7:0] id_byte(input logic [12:0] a);
    return (a[11:0] == 12'h100) ? D1 : ((a[11:0] == 12'h200) ? D2 : MK);
  endfunction

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic op(input logic [4:0] m, input logic [12:0] a, input logic [7:0] d);
    logic busy, ok;
    u_prog.prog(m, a, d, busy, ok);
    check("busy during op", {7'h0, busy}, 8'h01);
    check("op completes", {7'h0, ok}, 8'h01);
  endtask

  task automatic rd_chk(input logic [4:0] m, input logic [12:0] a, input logic [7:0] exp);
    u_prog.rd(m, a);
    check("port0 drive", {7'h0, oe}, 8'h01);
    check("port0 byte", p0_o, exp);
  endtask

  always @(posedge core_clk_i)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      err_total++;
      end_of_test();
    end
  end

  initial
  begin
    logic [12:0] a;
    logic [7:0] d;
    logic [4:0] lm [3];
    logic [12:0] aq [$];
    lm = '{`PFP_MODE_LOCK1, `PFP_MODE_LOCK2, `PFP_MODE_LOCK3};
    a = 13'($urandom(32'haded));
    repeat (2) @(posedge core_clk_i);
    #1 resetn_i = 1'b1;
    repeat (6) @(posedge core_clk_i);
    op(`PFP_MODE_ERASE, a, 8'h00);
    rd_chk(`PFP_MODE_READ, 13'h1fff, 8'hff);
    rd_chk(`PFP_MODE_LOCKRD, a, lock_byte(3'h0));
    $display("test erase done");
    for (int i = 0; i < 24; i++)
    begin
      a = (i == 0) ? 13'h0000 : ((i == 1) ? 13'h1fff : 13'($urandom()));
      d = (i == 2) ? 8'h00 : 8'($urandom());
      op(`PFP_MODE_WRITE, a, d);
      exp_mem[a] = d;
      aq.push_back(a);
    end
    foreach (aq[i]) rd_chk(`PFP_MODE_READ, aq[i], exp_mem[aq[i]]);
    $display("test write done");
    for (int i = 0; i < 3; i++)
    begin
      op(lm[i], 13'($urandom()), 8'($urandom()));
      rd_chk(`PFP_MODE_LOCKRD, 13'h0000, lock_byte(3'((2 << i) - 1)));
    end
    $display("test lock done");
    for (int i = 0; i < 5; i++)
    begin
      // odd steps also set the top address bit, which identity reads ignore
      a = (i == 4) ? 13'h0001 : 13'((i << 8) + ((i % 2) << 12));
      rd_chk(`PFP_MODE_ID, a, id_byte(a));
    end
    $display("test id done");
    op(`PFP_MODE_ERASE, 13'h0000, 8'h00);
    rd_chk(`PFP_MODE_READ, aq[2], 8'hff);
    rd_chk(`PFP_MODE_LOCKRD, 13'h0000, lock_byte(3'h0));
    $display("test erase again done");
    end_of_test();
  end
endmodule
`default_nettype wire
